// ---- hw/eeprom_rd_pkg.sv ----
package eeprom_rd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         SCL_PERIOD_NS = 2500;
  localparam int         QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [4:0] QTR_LAST      = 5'(QTR_CYC - 1);
  // ----------------------------------------
  // Array and protocol
  // ----------------------------------------
  localparam int          ADDR_W       = 13;
  localparam int          DATA_W       = 8;
  localparam int          MEM_DEPTH    = 8192;
  localparam logic [12:0] ADDR_TOP     = 13'h1FFF;
  localparam logic [12:0] ADDR_FIRST   = 13'h0000;
  localparam logic [3:0]  DEV_CODE     = 4'hA;
  localparam logic        DIR_READ     = 1'b1;
  localparam logic        DIR_WRITE    = 1'b0;
  localparam logic        ACK_BIT      = 1'b0;
  localparam logic        NACK_BIT     = 1'b1;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  ACK_SLOT     = 4'h8;
  localparam logic [3:0]  BYTE_DONE    = 4'h9;
  localparam logic [3:0]  BUSCLR_SLOTS = 4'h9;
  localparam logic [1:0]  ABYTE_HI     = 2'h1;
  localparam logic [1:0]  ABYTE_LO     = 2'h2;
  localparam int          FIFO_DEPTH   = 16;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [6:0] {
    DS_IDLE = 7'h01, DS_ADDR = 7'h02, DS_AACK = 7'h04, DS_WADR = 7'h08,
    DS_WACK = 7'h10, DS_SEND = 7'h20, DS_MACK = 7'h40
  } dev_state_t;
  typedef enum logic [9:0] {
    MS_CLR   = 10'h001, MS_IDLE  = 10'h002, MS_START = 10'h004, MS_DEVW = 10'h008,
    MS_HI    = 10'h010, MS_LO    = 10'h020, MS_DEVR  = 10'h040, MS_RDAT = 10'h080,
    MS_PUSH  = 10'h100, MS_MACK  = 10'h200
  } mst_state_t;
  typedef enum logic [2:0] {
    SL_START = 3'h1, SL_STOP = 3'h2, SL_BIT = 3'h4
  } slot_t;
endpackage

// ---- hw/eeprom_link_if.sv ----
interface eeprom_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic sda;
  // ----------------------------------------
  // Wired-AND open-drain data line
  // ----------------------------------------
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
  modport master (output scl, output sda_m_o, output sda_m_oe_n, input sda);
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe_n);
endinterface

// ---- hw/stream_fifo.sv ----
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_st_t;
  fifo_st_t         q;
  fifo_st_t         d;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic             push;
  logic             pop;
  // ----------------------------------------
  // Handshake and pointers
  // ----------------------------------------
  assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = mem[q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[q.wp] <= in_data_i;
    end
  end
endmodule

// ---- hw/eeprom_dev.sv ----
// Function
// - Direction bit one selects a read
// - Shared pointer holds location after last access
// - Pointer wraps from top location to zero
// - Acknowledge read address, then send pointed byte
// - Master ends single read with nack, stop
// - Random read starts with dummy address write
// - Repeated start, read address, byte from pointer
// - Master acknowledge asks for another byte
// - Each master acknowledge sends next location
// - Nack ends read, line released, stop
// - Whole array readable, wraps without stopping
// - Address is 1010, select bits, direction
// - Only a matching address is acknowledged
// - Master sends two address bytes, checks acks
module eeprom_dev (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  eeprom_link_if.device    link,
  input  wire logic        select_bit_high_i,
  input  wire logic        select_bit_mid_i,
  input  wire logic        select_bit_low_i,
  input  wire logic        fill_en_i,
  input  wire logic [12:0] fill_addr_i,
  input  wire logic [7:0]  fill_data_i,
  output logic             byte_sent_o
);
  typedef struct packed {
    eeprom_rd_pkg::dev_state_t st;
    logic [1:0]                rst_s;
    logic [2:0]                sel_s1;
    logic [2:0]                sel_s2;
    logic [2:0]                cnt;
    logic [7:0]                sr;
    logic                      rw;
    logic [1:0]                abyte;
    logic [4:0]                hi;
    logic [12:0]               ptr;
    logic [7:0]                tx;
    logic                      oe_n;
    logic                      sent_t;
  } link_st_t;
  typedef struct packed {
    logic pend;
    logic ack_s1;
    logic ack_s2;
    logic sent_s1;
    logic sent_s2;
    logic sent_s3;
    logic evt;
  } sys_st_t;
  localparam sys_st_t SYS_RST = '{pend: 1'b1, default: 1'b0};
  logic [7:0]  mem [0:eeprom_rd_pkg::MEM_DEPTH-1];
  link_st_t    lq;
  link_st_t    ld;
  sys_st_t     sq;
  sys_st_t     sd;
  logic        smp_q;
  logic        start;
  logic        stop;
  logic        load;
  logic [7:0]  sr_n;
  logic [7:0]  rd_byte;
  logic [12:0] ptr_next;
  // ----------------------------------------
  // Array fill port
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (fill_en_i) begin
      mem[fill_addr_i] <= fill_data_i;
    end
  end
  // ----------------------------------------
  // System side: reset request and byte event
  // ----------------------------------------
  always_comb begin
    sd         = sq;
    sd.ack_s1  = lq.rst_s[1];
    sd.ack_s2  = sq.ack_s1;
    sd.sent_s1 = lq.sent_t;
    sd.sent_s2 = sq.sent_s1;
    sd.sent_s3 = sq.sent_s2;
    sd.evt     = sq.sent_s2 ^ sq.sent_s3;
    if (sq.ack_s2) begin
      sd.pend = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sq <= SYS_RST;
    end else begin
      sq <= sd;
    end
  end
  assign byte_sent_o = sq.evt;
  // ----------------------------------------
  // Link side: bit sampled while clock high
  // ----------------------------------------
  always_ff @(posedge link.scl) begin
    smp_q <= link.sda;
  end
  assign start    = smp_q & ~link.sda;
  assign stop     = ~smp_q & link.sda;
  assign sr_n     = {lq.sr[6:0], smp_q};
  assign rd_byte  = mem[lq.ptr];
  assign ptr_next = (lq.ptr == eeprom_rd_pkg::ADDR_TOP) ? eeprom_rd_pkg::ADDR_FIRST : lq.ptr + 1'b1;
  // ----------------------------------------
  // Link side: byte engine on falling clock
  // ----------------------------------------
  always_comb begin
    ld        = lq;
    load      = 1'b0;
    ld.rst_s  = {lq.rst_s[0], sq.pend};
    ld.sel_s1 = {select_bit_high_i, select_bit_mid_i, select_bit_low_i};
    ld.sel_s2 = lq.sel_s1;
    if (lq.rst_s[1]) begin
      ld.st    = eeprom_rd_pkg::DS_IDLE;
      ld.cnt   = '0;
      ld.sr    = '0;
      ld.rw    = 1'b0;
      ld.abyte = '0;
      ld.hi    = '0;
      ld.ptr   = eeprom_rd_pkg::ADDR_FIRST;
      ld.tx    = '0;
      ld.oe_n  = 1'b1;
      ld.sent_t = 1'b0;
    end else if (start) begin
      ld.st   = eeprom_rd_pkg::DS_ADDR;
      ld.cnt  = '0;
      ld.oe_n = 1'b1;
    end else if (stop) begin
      ld.st   = eeprom_rd_pkg::DS_IDLE;
      ld.oe_n = 1'b1;
    end else begin
      case (lq.st)
        eeprom_rd_pkg::DS_ADDR: begin
          ld.sr  = sr_n;
          ld.cnt = lq.cnt + 1'b1;
          if (lq.cnt == eeprom_rd_pkg::BIT_LAST) begin
            if (sr_n[7:1] == {eeprom_rd_pkg::DEV_CODE, lq.sel_s2}) begin
              ld.st   = eeprom_rd_pkg::DS_AACK;
              ld.oe_n = 1'b0;
              ld.rw   = (sr_n[0] == eeprom_rd_pkg::DIR_READ);
            end else begin
              ld.st = eeprom_rd_pkg::DS_IDLE;
            end
          end
        end
        eeprom_rd_pkg::DS_AACK: begin
          if (lq.rw) begin
            load = 1'b1;
          end else begin
            ld.oe_n  = 1'b1;
            ld.st    = eeprom_rd_pkg::DS_WADR;
            ld.cnt   = '0;
            ld.abyte = '0;
          end
        end
        eeprom_rd_pkg::DS_WADR: begin
          ld.sr  = sr_n;
          ld.cnt = lq.cnt + 1'b1;
          if (lq.cnt == eeprom_rd_pkg::BIT_LAST) begin
            ld.st   = eeprom_rd_pkg::DS_WACK;
            ld.oe_n = 1'b0;
            if (lq.abyte == '0) begin
              ld.hi    = sr_n[4:0];
              ld.abyte = eeprom_rd_pkg::ABYTE_HI;
            end else begin
              ld.ptr   = {lq.hi, sr_n};
              ld.abyte = eeprom_rd_pkg::ABYTE_LO;
            end
          end
        end
        eeprom_rd_pkg::DS_WACK: begin
          ld.oe_n = 1'b1;
          ld.cnt  = '0;
          if (lq.abyte == eeprom_rd_pkg::ABYTE_LO) begin
            ld.st = eeprom_rd_pkg::DS_IDLE;
          end else begin
            ld.st = eeprom_rd_pkg::DS_WADR;
          end
        end
        eeprom_rd_pkg::DS_SEND: begin
          ld.cnt = lq.cnt + 1'b1;
          if (lq.cnt == eeprom_rd_pkg::BIT_LAST) begin
            ld.oe_n = 1'b1;
            ld.st   = eeprom_rd_pkg::DS_MACK;
          end else begin
            ld.tx   = {lq.tx[6:0], 1'b0};
            ld.oe_n = lq.tx[6];
          end
        end
        eeprom_rd_pkg::DS_MACK: begin
          if (smp_q == eeprom_rd_pkg::ACK_BIT) begin
            load = 1'b1;
          end else begin
            ld.st   = eeprom_rd_pkg::DS_IDLE;
            ld.oe_n = 1'b1;
          end
        end
        default: begin
          ld.oe_n = 1'b1;
        end
      endcase
      if (load) begin
        ld.tx     = rd_byte;
        ld.oe_n   = rd_byte[7];
        ld.ptr    = ptr_next;
        ld.cnt    = '0;
        ld.st     = eeprom_rd_pkg::DS_SEND;
        ld.sent_t = ~lq.sent_t;
      end
    end
  end
  always_ff @(negedge link.scl) begin
    lq <= ld;
  end
  assign link.sda_s_o    = 1'b0;
  assign link.sda_s_oe_n = lq.oe_n;
endmodule

// ---- hw/eeprom_host.sv ----
module eeprom_host (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  eeprom_link_if.master    link,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic        cmd_random_i,
  input  wire logic [2:0]  cmd_sel_i,
  input  wire logic [12:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_count_i,
  output logic             rd_valid_o,
  input  wire logic        rd_ready_i,
  output logic [7:0]       rd_data_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             nak_o
);
  typedef struct packed {
    eeprom_rd_pkg::mst_state_t st;
    eeprom_rd_pkg::slot_t      sl;
    logic                      busy;
    logic [1:0]                qt;
    logic [4:0]                div;
    logic [3:0]                bn;
    logic [7:0]                tx;
    logic [7:0]                rxsh;
    logic                      rx;
    logic                      rnd;
    logic [2:0]                sel;
    logic [12:0]               addr;
    logic [7:0]                rem;
    logic                      scl;
    logic                      oe_n;
    logic                      s1;
    logic                      s2;
    logic                      done;
    logic                      nak;
  } mst_st_t;
  localparam mst_st_t MST_RST = '{st: eeprom_rd_pkg::MS_CLR, sl: eeprom_rd_pkg::SL_BIT,
                                  scl: 1'b1, oe_n: 1'b1, default: '0};
  mst_st_t              q;
  mst_st_t              d;
  logic                 iss;
  eeprom_rd_pkg::slot_t iss_sl;
  logic                 iss_bit;
  logic                 push_rdy;
  // ----------------------------------------
  // Sequencer and bit slots
  // ----------------------------------------
  always_comb begin
    d       = q;
    iss     = 1'b0;
    iss_sl  = eeprom_rd_pkg::SL_BIT;
    iss_bit = 1'b1;
    d.s1    = link.sda;
    d.s2    = q.s1;
    d.done  = 1'b0;
    d.nak   = 1'b0;
    if (q.busy) begin
      if (q.div == eeprom_rd_pkg::QTR_LAST) begin
        d.div = '0;
        d.qt  = q.qt + 1'b1;
        case (q.qt)
          2'h0: d.scl = 1'b1;
          2'h1: begin
            if (q.sl == eeprom_rd_pkg::SL_START) begin
              d.oe_n = 1'b0;
            end else if (q.sl == eeprom_rd_pkg::SL_STOP) begin
              d.oe_n = 1'b1;
            end else begin
              d.rx   = q.s2;
              d.rxsh = {q.rxsh[6:0], q.s2};
            end
          end
          2'h2: d.scl = (q.sl == eeprom_rd_pkg::SL_STOP);
          default: d.busy = 1'b0;
        endcase
      end else begin
        d.div = q.div + 1'b1;
      end
    end else begin
      case (q.st)
        eeprom_rd_pkg::MS_CLR: begin
          if (q.bn != eeprom_rd_pkg::BUSCLR_SLOTS) begin
            iss  = 1'b1;
            d.bn = q.bn + 1'b1;
          end else begin
            iss    = 1'b1;
            iss_sl = eeprom_rd_pkg::SL_STOP;
            d.st   = eeprom_rd_pkg::MS_IDLE;
          end
        end
        eeprom_rd_pkg::MS_IDLE: begin
          if (cmd_valid_i) begin
            d.rnd  = cmd_random_i;
            d.sel  = cmd_sel_i;
            d.addr = cmd_addr_i;
            d.rem  = cmd_count_i;
            d.st   = eeprom_rd_pkg::MS_START;
            d.bn   = '0;
          end
        end
        eeprom_rd_pkg::MS_START: begin
          iss    = 1'b1;
          iss_sl = eeprom_rd_pkg::SL_START;
          d.bn   = '0;
          d.tx   = {eeprom_rd_pkg::DEV_CODE, q.sel, q.rnd ? eeprom_rd_pkg::DIR_WRITE : eeprom_rd_pkg::DIR_READ};
          d.st   = q.rnd ? eeprom_rd_pkg::MS_DEVW : eeprom_rd_pkg::MS_DEVR;
        end
        eeprom_rd_pkg::MS_DEVW, eeprom_rd_pkg::MS_HI, eeprom_rd_pkg::MS_LO, eeprom_rd_pkg::MS_DEVR: begin
          if (q.bn != eeprom_rd_pkg::BYTE_DONE) begin
            iss     = 1'b1;
            iss_bit = (q.bn == eeprom_rd_pkg::ACK_SLOT) ? 1'b1 : q.tx[eeprom_rd_pkg::BIT_LAST - q.bn[2:0]];
            d.bn    = q.bn + 1'b1;
          end else if (q.rx == eeprom_rd_pkg::NACK_BIT) begin
            d.nak  = 1'b1;
            iss    = 1'b1;
            iss_sl = eeprom_rd_pkg::SL_STOP;
            d.st   = eeprom_rd_pkg::MS_IDLE;
          end else begin
            d.bn = '0;
            case (q.st)
              eeprom_rd_pkg::MS_DEVW: begin
                d.tx = {3'h0, q.addr[12:8]};
                d.st = eeprom_rd_pkg::MS_HI;
              end
              eeprom_rd_pkg::MS_HI: begin
                d.tx = q.addr[7:0];
                d.st = eeprom_rd_pkg::MS_LO;
              end
              eeprom_rd_pkg::MS_LO: begin
                d.rnd = 1'b0;
                d.st  = eeprom_rd_pkg::MS_START;
              end
              default: d.st = eeprom_rd_pkg::MS_RDAT;
            endcase
          end
        end
        eeprom_rd_pkg::MS_RDAT: begin
          if (q.bn[3]) begin
            d.st = eeprom_rd_pkg::MS_PUSH;
          end else begin
            iss  = 1'b1;
            d.bn = q.bn + 1'b1;
          end
        end
        eeprom_rd_pkg::MS_PUSH: begin
          if (push_rdy) begin
            iss     = 1'b1;
            iss_bit = (q.rem == '0) ? eeprom_rd_pkg::NACK_BIT : eeprom_rd_pkg::ACK_BIT;
            d.st    = eeprom_rd_pkg::MS_MACK;
          end
        end
        eeprom_rd_pkg::MS_MACK: begin
          d.bn = '0;
          if (q.rem == '0) begin
            iss    = 1'b1;
            iss_sl = eeprom_rd_pkg::SL_STOP;
            d.done = 1'b1;
            d.st   = eeprom_rd_pkg::MS_IDLE;
          end else begin
            d.rem = q.rem - 1'b1;
            d.st  = eeprom_rd_pkg::MS_RDAT;
          end
        end
        default: d.st = eeprom_rd_pkg::MS_IDLE;
      endcase
      if (iss) begin
        d.busy = 1'b1;
        d.sl   = iss_sl;
        d.qt   = '0;
        d.div  = '0;
        d.scl  = 1'b0;
        case (iss_sl)
          eeprom_rd_pkg::SL_START: d.oe_n = 1'b1;
          eeprom_rd_pkg::SL_STOP: d.oe_n = 1'b0;
          default: d.oe_n = iss_bit;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= MST_RST;
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------
  // Read data buffer
  // ----------------------------------------
  stream_fifo #(.WIDTH(eeprom_rd_pkg::DATA_W), .DEPTH(eeprom_rd_pkg::FIFO_DEPTH)) u_stream_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (!q.busy && (q.st == eeprom_rd_pkg::MS_PUSH)),
    .in_ready_o  (push_rdy),
    .in_data_i   (q.rxsh),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );
  assign link.scl        = q.scl;
  assign link.sda_m_o    = 1'b0;
  assign link.sda_m_oe_n = q.oe_n;
  assign cmd_ready_o     = !q.busy && (q.st == eeprom_rd_pkg::MS_IDLE);
  assign busy_o          = !cmd_ready_o;
  assign done_o          = q.done;
  assign nak_o           = q.nak;
endmodule

// ---- testbench/eeprom_link_monitor.sv ----
module eeprom_link_monitor (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic scl,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic sda,
  input wire logic select_bit_high_i,
  input wire logic select_bit_mid_i,
  input wire logic select_bit_low_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       first_q;
  logic       rd_q;
  logic       rel_q;
  logic       rise;
  logic       start_ev;
  logic       stop_ev;
  logic       match;
  logic       ack9;
  assign rise     = scl & ~scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev  = scl & scl_q & ~sda_q & sda;
  assign match    = sh_q[7:1] == {eeprom_rd_pkg::DEV_CODE, select_bit_high_i, select_bit_mid_i, select_bit_low_i};
  assign ack9     = rise & (cnt_q == eeprom_rd_pkg::ACK_SLOT);
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
      rel_q   <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        cnt_q   <= 4'h0;
        first_q <= 1'b1;
        rd_q    <= 1'b0;
        rel_q   <= 1'b0;
      end else if (rise) begin
        cnt_q <= ack9 ? 4'h0 : cnt_q + 4'h1;
        if (!ack9) begin
          sh_q <= {sh_q[6:0], sda};
        end else begin
          first_q <= 1'b0;
          if (first_q && match && sh_q[0] == eeprom_rd_pkg::DIR_READ) rd_q <= 1'b1;
          if (!first_q && rd_q && sda) rel_q <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_DEV_EDGE: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("device data changed while clock high");
  AST_SDA_STABLE: assert property (scl && $past(scl) && $changed(sda) |-> $changed(sda_m_oe_n))
    else $error("data line moved in clock high without master");
  AST_ADDR_ACK: assert property (ack9 && first_q && match |-> (!sda_s_oe_n) [*8])
    else $error("matching address not acknowledged");
  AST_ADDR_SILENT: assert property (ack9 && first_q && !match |-> sda_s_oe_n)
    else $error("foreign address acknowledged");
  AST_HOST_WAITS_ACK: assert property (ack9 && (first_q || !rd_q) |-> sda_m_oe_n)
    else $error("master drove device acknowledge slot");
  AST_DEV_REL_MACK: assert property (ack9 && rd_q && !first_q |-> sda_s_oe_n)
    else $error("device drove master acknowledge slot");
  AST_HOST_REL_DATA: assert property (rise && rd_q && !first_q && !rel_q && !ack9 |-> sda_m_oe_n)
    else $error("master drove data bit of a read");
  AST_NACK_RELEASE: assert property (rel_q |-> sda_s_oe_n)
    else $error("device drove line after master nack");
  AST_STOP_AFTER_NACK: assert property (ack9 && rd_q && !first_q && sda |-> ##[1:300] stop_ev)
    else $error("no stop after master nack");
  COV_SEQ: cover property (ack9 && rd_q && !first_q && !sda);
  COV_NACK: cover property (rel_q);
  COV_FOREIGN: cover property (ack9 && first_q && !match);
endmodule

// ---- testbench/tb_serial_eeprom_read_path.sv ----
module tb_serial_eeprom_read_path;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] STRAP = 3'h5;
  logic        clk_sys_i;
  logic        sys_rst_i;
  logic        cmd_valid_i;
  logic        cmd_ready_o;
  logic        cmd_random_i;
  logic [2:0]  cmd_sel_i;
  logic [12:0] cmd_addr_i;
  logic [7:0]  cmd_count_i;
  logic        rd_valid_o;
  logic        rd_ready_i;
  logic [7:0]  rd_data_o;
  logic        busy_o;
  logic        done_o;
  logic        nak_o;
  logic        byte_sent_o;
  logic        fill_en_i;
  logic [12:0] fill_addr_i;
  logic [7:0]  fill_data_i;
  logic [12:0] ptr;
  int          fail_count;
  int          samples_checked;
  eeprom_link_if u_eeprom_link_if ();
  eeprom_host u_eeprom_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(u_eeprom_link_if),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_random_i(cmd_random_i), .cmd_sel_i(cmd_sel_i),
    .cmd_addr_i(cmd_addr_i), .cmd_count_i(cmd_count_i), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .rd_data_o(rd_data_o), .busy_o(busy_o), .done_o(done_o), .nak_o(nak_o));
  eeprom_dev u_eeprom_dev (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(u_eeprom_link_if),
    .select_bit_high_i(STRAP[2]), .select_bit_mid_i(STRAP[1]), .select_bit_low_i(STRAP[0]),
    .fill_en_i(fill_en_i), .fill_addr_i(fill_addr_i), .fill_data_i(fill_data_i), .byte_sent_o(byte_sent_o));
  eeprom_link_monitor u_eeprom_link_monitor (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .scl(u_eeprom_link_if.scl), .sda_m_oe_n(u_eeprom_link_if.sda_m_oe_n), .sda_s_oe_n(u_eeprom_link_if.sda_s_oe_n),
    .sda(u_eeprom_link_if.sda), .select_bit_high_i(STRAP[2]), .select_bit_mid_i(STRAP[1]),
    .select_bit_low_i(STRAP[0]));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] exp_byte(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h5};
  endfunction
  task automatic fail(input string msg);
    fail_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) fail("flag mismatch");
  endtask
  task automatic check_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run_cmd(input logic rnd, input logic [2:0] sel, input logic [12:0] adr, input logic [7:0] cnt,
                         input int stall, input logic exp_nak);
    int          k;
    int          n;
    int          s;
    logic        fin;
    logic        quit;
    logic [12:0] a;
    n = 0;
    s = 0;
    fin = 1'b0;
    quit = 1'b0;
    a = adr;
    for (k = 0; k < 3000 && cmd_ready_o !== 1'b1; k++) @(negedge clk_sys_i);
    check_flag(busy_o, 1'b0);
    @(posedge clk_sys_i);
    cmd_valid_i  <= 1'b1;
    cmd_random_i <= rnd;
    cmd_sel_i    <= sel;
    cmd_addr_i   <= adr;
    cmd_count_i  <= cnt;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    check_flag(busy_o, 1'b1);
    for (k = 0; k < 60000 && !quit; k++) begin
      @(negedge clk_sys_i);
      if (byte_sent_o === 1'b1) s++;
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
        check_byte(rd_data_o, exp_byte(a));
        a = a + 13'h1;
        n++;
      end
      if (done_o === 1'b1 || nak_o === 1'b1) begin
        check_flag(nak_o, exp_nak);
        fin = 1'b1;
      end
      quit = fin && rd_valid_o !== 1'b1;
      @(posedge clk_sys_i);
      rd_ready_i <= (k >= stall);
    end
    if (!fin) fail("command did not finish");
    check_count(n, exp_nak ? 0 : int'(cnt) + 1);
    check_count(s, exp_nak ? 0 : int'(cnt) + 1);
    if (!exp_nak) ptr = a;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fill();
    for (int i = 0; i < 8192; i++) begin
      @(posedge clk_sys_i);
      fill_en_i   <= 1'b1;
      fill_addr_i <= 13'(i);
      fill_data_i <= exp_byte(13'(i));
    end
    @(posedge clk_sys_i);
    fill_en_i <= 1'b0;
  endtask
  task automatic t_current_read();
    run_cmd(1'b0, STRAP, ptr, 8'h00, 0, 1'b0);
  endtask
  task automatic t_random_wrap();
    run_cmd(1'b1, STRAP, 13'h1FFE, 8'h03, 0, 1'b0);
    run_cmd(1'b1, STRAP, 13'h0AB5, 8'h00, 0, 1'b0);
  endtask
  task automatic t_wrong_sel();
    run_cmd(1'b0, STRAP ^ 3'h1, ptr, 8'h00, 0, 1'b1);
  endtask
  task automatic t_fifo_stall();
    run_cmd(1'b0, STRAP, ptr, 8'h13, 17000, 1'b0);
  endtask
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    fail("watchdog expired");
    report_and_stop();
  end
  initial begin
    fail_count = 0;
    samples_checked = 0;
    ptr = 13'h0000;
    sys_rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_random_i = 1'b0;
    cmd_sel_i = 3'h0;
    cmd_addr_i = 13'h0000;
    cmd_count_i = 8'h00;
    rd_ready_i = 1'b1;
    fill_en_i = 1'b0;
    fill_addr_i = 13'h0000;
    fill_data_i = 8'h00;
    repeat (10) @(posedge clk_sys_i);
    check_flag(cmd_ready_o, 1'b0);
    sys_rst_i <= 1'b0;
    t_fill();
    t_current_read();
    t_random_wrap();
    t_wrong_sel();
    t_fifo_stall();
    t_current_read();
    report_and_stop();
  end
endmodule
